// ### verilog/dswc_wake_cfg.sv
// wake source enables and deep-sleep power configuration, wishbone slave
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module dswc_wake_cfg
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] pin_irq_i,
   input wire logic watchdog_irq_i,
   input wire logic brownout_irq_i,
   input wire logic usb_need_clock_i,
   input wire logic [1:0] group_irq_i,
   input wire logic deep_sleep_i,
   input wire logic wdt_lock_i,
   output logic wake_req_o,
   output logic run_cfg_load_o,
   output logic run_brownout_pd_o,
   output logic run_watchdog_osc_pd_o,
   output logic analog_force_pd_o,
   output logic irq_o
);

   dswc_pkg::dswc_wb_req_type req;
   logic [31:0] pin_wake_enable;
   logic [31:0] peripheral_wake_enable;
   logic [31:0] sleep_power_config;
   logic [31:0] ctrl;
   logic [31:0] irq_mask;
   logic [2:0] irq_status;
   logic [31:0] next_pin_wake_enable;
   logic [31:0] next_peripheral_wake_enable;
   logic [31:0] next_sleep_power_config;
   logic [31:0] next_ctrl;
   logic [31:0] next_irq_mask;
   logic [2:0] next_irq_status;
   logic next_irq;
   logic [31:0] next_dat;
   logic next_ack;
   logic access;
   logic wr;
   logic rd_status;
   logic in_sleep;
   logic next_in_sleep;
   logic next_wake_req;
   logic next_load;
   logic next_run_brownout;
   logic next_run_wdt;
   logic sleep_entry;
   logic usb_edge;
   logic usb_level;
   logic [31:0] periph_src;
   logic wake_hit;
   logic [2:0] events;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdat,
                                         input logic [3:0] sel,
                                         input logic [31:0] mask);
      logic [31:0] lanes;
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~(lanes & mask)) | (wdat & lanes & mask);
   endfunction

   assign req.adr = wb_adr_i;
   assign req.dat = wb_dat_i;
   assign req.sel = wb_sel_i;
   assign req.we = wb_we_i;

   dswc_usb_edge u_usb_edge
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .need_clock_i(usb_need_clock_i),
      .polarity_i(ctrl[dswc_pkg::CTRL_POL_BIT]),
      .edge_o(usb_edge),
      .level_o(usb_level)
   );

   // access takes effect only on the cycle the ack is raised
   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = access && req.we;
   assign rd_status = access && !req.we
                      && (req.adr == dswc_pkg::ADDR_IRQ_STATUS);

   // wake source vector laid out like the peripheral enable register
   always_comb
   begin
      periph_src = 32'h0000_0000;
      periph_src[dswc_pkg::WATCHDOG_BIT] = watchdog_irq_i;
      periph_src[dswc_pkg::BROWNOUT_BIT] = brownout_irq_i;
      periph_src[dswc_pkg::USB_BIT] = usb_edge;
      periph_src[dswc_pkg::GROUP0_BIT] = group_irq_i[0];
      periph_src[dswc_pkg::GROUP1_BIT] = group_irq_i[1];
      wake_hit = |(pin_irq_i & pin_wake_enable[7:0]);
      wake_hit = wake_hit | (|(periph_src & peripheral_wake_enable));
   end

   // register group
   always_comb
   begin
      next_pin_wake_enable = pin_wake_enable;
      next_peripheral_wake_enable = peripheral_wake_enable;
      next_sleep_power_config = sleep_power_config;
      next_ctrl = ctrl;
      next_irq_mask = irq_mask;
      if (wr)
      begin
         unique case (req.adr)
            dswc_pkg::ADDR_PIN_WAKE:
               next_pin_wake_enable = merge(pin_wake_enable, req.dat,
                  req.sel, dswc_pkg::PIN_WAKE_MASK);
            dswc_pkg::ADDR_PERIPH_WAKE:
               next_peripheral_wake_enable = merge(peripheral_wake_enable,
                  req.dat, req.sel, dswc_pkg::PERIPH_WAKE_MASK);
            dswc_pkg::ADDR_SLEEP_CFG:
               next_sleep_power_config = merge(sleep_power_config, req.dat,
                  req.sel, dswc_pkg::SLEEP_CFG_MASK);
            dswc_pkg::ADDR_CTRL:
               next_ctrl = merge(ctrl, req.dat, req.sel,
                  dswc_pkg::CTRL_MASK);
            dswc_pkg::ADDR_IRQ_MASK:
               next_irq_mask = merge(irq_mask, req.dat, req.sel,
                  dswc_pkg::IRQ_MASK_MASK);
            default:
               next_ctrl = ctrl;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_wake_enable <= dswc_pkg::PIN_WAKE_RESET;
         peripheral_wake_enable <= dswc_pkg::PERIPH_WAKE_RESET;
         sleep_power_config <= dswc_pkg::SLEEP_CFG_RESET;
         ctrl <= dswc_pkg::CTRL_RESET;
         irq_mask <= dswc_pkg::IRQ_MASK_RESET;
      end
      else
      begin
         pin_wake_enable <= next_pin_wake_enable;
         peripheral_wake_enable <= next_peripheral_wake_enable;
         sleep_power_config <= next_sleep_power_config;
         ctrl <= next_ctrl;
         irq_mask <= next_irq_mask;
      end
   end

   // sleep group
   always_comb
   begin
      sleep_entry = deep_sleep_i && !in_sleep;
      next_in_sleep = deep_sleep_i;
      next_load = sleep_entry;
      next_run_brownout = run_brownout_pd_o;
      next_run_wdt = run_watchdog_osc_pd_o;
      if (sleep_entry)
      begin
         next_run_brownout = sleep_power_config[dswc_pkg::SLEEP_BROWNOUT_BIT];
         next_run_wdt = wdt_lock_i ? 1'h0
            : sleep_power_config[dswc_pkg::SLEEP_WDT_OSC_BIT];
      end
      // wake request held until sleep ends
      next_wake_req = deep_sleep_i && (wake_req_o || (in_sleep && wake_hit));
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         in_sleep <= 1'h0;
         wake_req_o <= 1'h0;
         run_cfg_load_o <= 1'h0;
         run_brownout_pd_o <= dswc_pkg::RUN_BROWNOUT_PD_RESET;
         run_watchdog_osc_pd_o <= dswc_pkg::RUN_WATCHDOG_OSC_PD_RESET;
         analog_force_pd_o <= 1'h0;
      end
      else
      begin
         in_sleep <= next_in_sleep;
         wake_req_o <= next_wake_req;
         run_cfg_load_o <= next_load;
         run_brownout_pd_o <= next_run_brownout;
         run_watchdog_osc_pd_o <= next_run_wdt;
         analog_force_pd_o <= next_in_sleep;
      end
   end

   // interrupt group: set beats the clear-on-read
   always_comb
   begin
      events = 3'h0;
      events[dswc_pkg::EVT_WAKE_BIT] = next_wake_req && !wake_req_o;
      events[dswc_pkg::EVT_USB_BIT] = usb_edge;
      events[dswc_pkg::EVT_SLEEP_BIT] = sleep_entry;
      next_irq_status = (rd_status ? 3'h0 : irq_status) | events;
      next_irq = |(next_irq_status & next_irq_mask[2:0]);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status <= 3'h0;
         irq_o <= 1'h0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq_o <= next_irq;
      end
   end

   // bus group: one wait state, unmapped reads give zero
   always_comb
   begin
      next_ack = access;
      next_dat = 32'h0000_0000;
      if (access && !req.we)
      begin
         unique case (req.adr)
            dswc_pkg::ADDR_PIN_WAKE: next_dat = pin_wake_enable;
            dswc_pkg::ADDR_PERIPH_WAKE: next_dat = peripheral_wake_enable;
            dswc_pkg::ADDR_SLEEP_CFG: next_dat = sleep_power_config;
            dswc_pkg::ADDR_CTRL: next_dat = ctrl;
            dswc_pkg::ADDR_IRQ_STATUS: next_dat = {29'h0, irq_status};
            dswc_pkg::ADDR_IRQ_MASK: next_dat = irq_mask;
            dswc_pkg::ADDR_STATE:
            begin
               next_dat[dswc_pkg::ST_SLEEP_BIT] = in_sleep;
               next_dat[dswc_pkg::ST_WAKE_BIT] = wake_req_o;
               next_dat[dswc_pkg::ST_RUN_BROWNOUT_BIT] = run_brownout_pd_o;
               next_dat[dswc_pkg::ST_RUN_WDT_BIT] = run_watchdog_osc_pd_o;
               next_dat[dswc_pkg::ST_USB_LVL_BIT] = usb_level;
            end
            default: next_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'h0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence wr_to(logic [31:0] a, int lane);
      wr && req.adr == a && req.sel[lane];
   endsequence

   chk_pin_enable_write: assert property (
      wr_to(dswc_pkg::ADDR_PIN_WAKE, 0) |=>
      pin_wake_enable[7:0] == $past(wb_dat_i[7:0]))
      else $error("pin wake enable not stored");

   chk_watchdog_enable_write: assert property (
      wr_to(dswc_pkg::ADDR_PERIPH_WAKE, 1) |=>
      peripheral_wake_enable[12] == $past(wb_dat_i[12]))
      else $error("watchdog wake enable not stored");

   chk_brownout_enable_write: assert property (
      wr_to(dswc_pkg::ADDR_PERIPH_WAKE, 1) |=>
      peripheral_wake_enable[13] == $past(wb_dat_i[13]))
      else $error("brown-out wake enable not stored");

   chk_usb_enable_write: assert property (
      wr_to(dswc_pkg::ADDR_PERIPH_WAKE, 2) |=>
      peripheral_wake_enable[19] == $past(wb_dat_i[19]))
      else $error("usb wake enable not stored");

   chk_group_enable_write: assert property (
      wr_to(dswc_pkg::ADDR_PERIPH_WAKE, 2) |=>
      peripheral_wake_enable[21:20] == $past(wb_dat_i[21:20]))
      else $error("group wake enables not stored");

   chk_run_copy_entry: assert property (
      $rose(deep_sleep_i) |=> run_cfg_load_o
      && run_brownout_pd_o == $past(sleep_power_config[3]))
      else $error("brown-out bit not copied on sleep entry");

   chk_analog_forced_down: assert property (
      deep_sleep_i [*2] |-> analog_force_pd_o)
      else $error("analog force missing during sleep");

   chk_wdt_lock_override: assert property (
      $rose(deep_sleep_i) |=> run_watchdog_osc_pd_o == (!$past(wdt_lock_i)
      && $past(sleep_power_config[6])))
      else $error("watchdog osc copy ignores lock");

   chk_sleep_cfg_reset: assert property (
      $past(rst_i) |-> sleep_power_config[6] && sleep_power_config[3])
      else $error("sleep config reset value wrong");

   chk_sleep_cfg_read: assert property (
      access && !wb_we_i && wb_adr_i == dswc_pkg::ADDR_SLEEP_CFG |=>
      wb_ack_o && wb_dat_o[31:7] == 25'h0)
      else $error("sleep config read shows reserved high bits");

   chk_wake_raised: assert property (
      in_sleep && deep_sleep_i && wake_hit |=> wake_req_o)
      else $error("enabled source in sleep gave no wake request");

   chk_wake_cause: assert property (
      $rose(wake_req_o) |-> $past(wake_hit) && $past(in_sleep))
      else $error("wake request without enabled source");

endmodule // dswc_wake_cfg
`default_nettype wire

// ### common/dswc_pkg.sv
// constants and carrier types for the deep-sleep wake configuration block
package dswc_pkg;

   // register byte addresses
   localparam logic [31:0] ADDR_PIN_WAKE = 32'h4004_8204;
   localparam logic [31:0] ADDR_PERIPH_WAKE = 32'h4004_8214;
   localparam logic [31:0] ADDR_SLEEP_CFG = 32'h4004_8230;
   localparam logic [31:0] ADDR_CTRL = 32'h4004_8240;
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4004_8244;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h4004_8248;
   localparam logic [31:0] ADDR_STATE = 32'h4004_824c;

   // writable bits of each register
   localparam logic [31:0] PIN_WAKE_MASK = 32'h0000_00ff;
   localparam logic [31:0] PERIPH_WAKE_MASK = 32'h0038_3000;
   localparam logic [31:0] SLEEP_CFG_MASK = 32'h0000_007f;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
   localparam logic [31:0] IRQ_MASK_MASK = 32'h0000_0007;

   // reset values
   localparam logic [31:0] PIN_WAKE_RESET = 32'h0000_0000;
   localparam logic [31:0] PERIPH_WAKE_RESET = 32'h0000_0000;
   localparam logic [31:0] SLEEP_CFG_RESET = 32'h0000_007f;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;
   localparam logic RUN_BROWNOUT_PD_RESET = 1'h0;
   localparam logic RUN_WATCHDOG_OSC_PD_RESET = 1'h1;

   // peripheral wake enable fields
   localparam int WATCHDOG_BIT = 12;
   localparam int BROWNOUT_BIT = 13;
   localparam int USB_BIT = 19;
   localparam int GROUP0_BIT = 20;
   localparam int GROUP1_BIT = 21;

   // sleep power config fields
   localparam int SLEEP_BROWNOUT_BIT = 3;
   localparam int SLEEP_WDT_OSC_BIT = 6;

   // control register: usb wake polarity
   localparam int CTRL_POL_BIT = 0;

   // interrupt status fields
   localparam int EVT_WAKE_BIT = 0;
   localparam int EVT_USB_BIT = 1;
   localparam int EVT_SLEEP_BIT = 2;

   // state register fields
   localparam int ST_SLEEP_BIT = 0;
   localparam int ST_WAKE_BIT = 1;
   localparam int ST_RUN_BROWNOUT_BIT = 2;
   localparam int ST_RUN_WDT_BIT = 3;
   localparam int ST_USB_LVL_BIT = 4;

   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
   } dswc_wb_req_type;

endpackage

// ### verilog/dswc_usb_edge.sv
// usb clock-request synchroniser and polarity-selected edge detector
`timescale 1ns/1ps
`default_nettype none
module dswc_usb_edge
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic need_clock_i,
   input wire logic polarity_i,
   output logic edge_o,
   output logic level_o
);

   logic sync1;
   logic sync2;
   logic sync3;
   logic stable;
   logic next_stable;
   logic next_edge;

   always_comb
   begin
      next_stable = stable;
      // glitch of one sample is ignored until two stages agree
      if (sync2 == sync3)
      begin
         next_stable = sync3;
      end
      next_edge = (next_stable != stable) && (next_stable == polarity_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1 <= 1'h0;
         sync2 <= 1'h0;
         sync3 <= 1'h0;
         stable <= 1'h0;
         edge_o <= 1'h0;
      end
      else
      begin
         sync1 <= need_clock_i;
         sync2 <= sync1;
         sync3 <= sync2;
         stable <= next_stable;
         edge_o <= next_edge;
      end
   end

   assign level_o = stable;

   chk_usb_edge_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_o |-> (stable == polarity_i) && ($past(stable) != stable))
      else $error("usb wake edge does not match polarity");

endmodule // dswc_usb_edge
`default_nettype wire

// ### bench/dswc_power_model.sv
// power controller model that enters and leaves deep sleep
`timescale 1ns/1ps
`default_nettype none
module dswc_power_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sleep_cmd_i,
   input wire logic slow_i,
   input wire logic wake_req_i,
   output logic deep_sleep_o
);
   logic woke;
   logic [2:0] cnt;
   // leaves sleep three or six cycles after a wake request rises
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !sleep_cmd_i)
      begin
         deep_sleep_o <= 1'h0;
         woke <= 1'h0;
         cnt <= 3'h0;
      end
      else if (!woke)
      begin
         deep_sleep_o <= 1'h1;
         woke <= wake_req_i;
         cnt <= slow_i ? 3'h4 : 3'h1;
      end
      else if (cnt != 3'h0)
         cnt <= cnt - 3'h1;
      else
         deep_sleep_o <= 1'h0;
   end
endmodule // dswc_power_model
`default_nettype wire

// ### bench/deep_sleep_wake_config_test.sv
// self-checking bench for the deep-sleep wake configuration block
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_wake_config_test;
   logic clk, rst, cyc, stb, we, usb, lock, slp, slow;
   logic [31:0] adr, wdat, dat_o;
   logic [3:0] sel;
   logic [11:0] src;
   logic ack, deep, wake, load, run_brownout, run_wdt, analog, irq;
   int num_errors = 0;
   int checks = 0;

   dswc_wake_cfg dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .pin_irq_i(src[7:0]), .watchdog_irq_i(src[8]),
      .brownout_irq_i(src[9]), .usb_need_clock_i(usb),
      .group_irq_i(src[11:10]),
      .deep_sleep_i(deep), .wdt_lock_i(lock), .wake_req_o(wake),
      .run_cfg_load_o(load), .run_brownout_pd_o(run_brownout),
      .run_watchdog_osc_pd_o(run_wdt), .analog_force_pd_o(analog),
      .irq_o(irq));

   dswc_power_model model_u (.clk_i(clk), .rst_i(rst), .sleep_cmd_i(slp),
      .slow_i(slow), .wake_req_i(wake), .deep_sleep_o(deep));

   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // request held until ack is sampled high, then released
   task automatic bus(input logic w, input logic [31:0] a, d,
      input logic [3:0] s, output logic [31:0] q);
      int n;
      @(posedge clk);
      {cyc, stb, we} <= {2'h3, w};
      adr <= a;
      wdat <= d;
      sel <= s;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'h1 && n < 20);
      q = dat_o;
      chk("ack", ack, 32'h1);
      {cyc, stb} <= 2'h0;
   endtask

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      bus(1'h1, a, d, 4'hf, q);
   endtask

   task automatic rd(input string nm, input logic [31:0] a, exp);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, 4'hf, q);
      chk(nm, q, exp);
   endtask

   task automatic t_reset();
      chk("run_brownout", run_brownout, 32'h0);
      chk("run_wdt", run_wdt, 32'h1);
      rd("pin", dswc_pkg::ADDR_PIN_WAKE, 32'h0);
      rd("periph", dswc_pkg::ADDR_PERIPH_WAKE,
         32'h0);
      rd("sleep", dswc_pkg::ADDR_SLEEP_CFG, 32'h7f);
   endtask

   task automatic t_regs();
      logic [31:0] q;
      wr(dswc_pkg::ADDR_PIN_WAKE, 32'hffff_ffff);
      wr(dswc_pkg::ADDR_PERIPH_WAKE, 32'hffff_ffff);
      wr(dswc_pkg::ADDR_SLEEP_CFG, 32'hffff_ff80);
      wr(32'h4004_8218, 32'hffff_ffff);
      rd("pin", dswc_pkg::ADDR_PIN_WAKE, 32'hff);
      rd("periph", dswc_pkg::ADDR_PERIPH_WAKE,
         32'h38_3000);
      rd("sleep", dswc_pkg::ADDR_SLEEP_CFG, 32'h0);
      rd("unmapped", 32'h4004_8218, 32'h0);
      // lane 2 disabled keeps bits 21:19
      bus(1'h1, dswc_pkg::ADDR_PERIPH_WAKE, 32'h0, 4'hb, q);
      rd("lanes", dswc_pkg::ADDR_PERIPH_WAKE, 32'h38_0000);
      wr(dswc_pkg::ADDR_SLEEP_CFG, 32'h7f);
   endtask

   task automatic t_copy(input logic [31:0] cfg, input logic lk, eb, ew);
      int n;
      wr(dswc_pkg::ADDR_IRQ_MASK, 32'h4);
      wr(dswc_pkg::ADDR_SLEEP_CFG, cfg);
      lock <= lk;
      slp <= 1'h1;
      for (n = 0; n < 8 && load !== 1'h1; n++) @(posedge clk);
      chk("load", load, 32'h1);
      chk("run_brownout", run_brownout, eb);
      chk("run_wdt", run_wdt, ew);
      chk("analog", analog, 32'h1);
      for (n = 0; n < 4 && irq !== 1'h1; n++) @(posedge clk);
      chk("irq", irq, 32'h1);
      rd("status", dswc_pkg::ADDR_IRQ_STATUS, 32'h4);
      repeat (2) @(posedge clk);
      chk("irq clear", irq, 32'h0);
      rd("sleep kept", dswc_pkg::ADDR_SLEEP_CFG, cfg);
      rd("state", dswc_pkg::ADDR_STATE, {28'h0, ew, eb, 2'h1});
      wr(dswc_pkg::ADDR_IRQ_MASK, 32'h0);
      {slp, lock} <= 2'h0;
      repeat (3) @(posedge clk);
      chk("analog off", analog, 32'h0);
   endtask

   task automatic t_wake(input int i, input logic en);
      int n;
      int bits [4] = '{12, 13, 20, 21};
      logic [31:0] per;
      per = (i >= 8 && en) ? 32'h1 << bits[i-8] : 32'h0;
      // upstream irq controller enable taken as set
      wr(dswc_pkg::ADDR_PIN_WAKE, (i < 8 && en) ? 32'h1 << i : 32'h0);
      wr(dswc_pkg::ADDR_PERIPH_WAKE, per);
      src <= 12'h1 << i;
      repeat (4) @(posedge clk);
      chk("wake awake", wake, 32'h0);
      src <= 12'h0;
      slow <= i[0];
      slp <= 1'h1;
      for (n = 0; n < 4 && deep !== 1'h1; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      src <= 12'h1 << i;
      for (n = 0; n < 6 && wake !== 1'h1; n++) @(posedge clk);
      chk("wake", wake, en);
      chk("irq masked", irq, 32'h0);
      src <= 12'h0;
      repeat (8) @(posedge clk);
      chk("wake drop", wake, 32'h0);
      slp <= 1'h0;
      repeat (2) @(posedge clk);
   endtask

   task automatic t_usb(input logic pol);
      int n;
      wr(dswc_pkg::ADDR_CTRL, {31'h0, pol});
      wr(dswc_pkg::ADDR_PERIPH_WAKE, 32'h8_0000);
      usb <= pol;
      repeat (8) @(posedge clk);
      {slp, slow} <= 2'h3;
      for (n = 0; n < 4 && deep !== 1'h1; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      usb <= !pol;
      repeat (8) @(posedge clk);
      chk("usb wrong edge", wake, 32'h0);
      usb <= pol;
      for (n = 0; n < 10 && wake !== 1'h1; n++) @(posedge clk);
      chk("usb wake", wake, 32'h1);
      rd("usb status", dswc_pkg::ADDR_IRQ_STATUS, 32'h7);
      slp <= 1'h0;
      repeat (3) @(posedge clk);
   endtask

   // whole run needs about 600 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   initial
   begin
      rst = 1'h1;
      {cyc, stb, we, usb, lock, slp, slow} = 7'h0;
      adr = 32'h0;
      wdat = 32'h0;
      sel = 4'h0;
      src = 12'h0;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_reset();
      t_regs();
      t_copy(32'h77, 1'h0, 1'h0, 1'h1);
      t_copy(32'h08, 1'h0, 1'h1, 1'h0);
      t_copy(32'h7f, 1'h1, 1'h1, 1'h0);
      for (int i = 0; i < 12; i++) t_wake(i, 1'h1);
      t_wake(3, 1'h0);
      t_wake(10, 1'h0);
      t_usb(1'h0);
      t_usb(1'h1);
      wrap_up();
   end
endmodule // deep_sleep_wake_config_test
`default_nettype wire
